// *** testbench/ifs_engine_model.sv ***
/*
  Behavioural serial engine: drains tx bytes, pushes rx bytes, raises slave events.
  Assumes the bench changes its controls just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ifs_defs.svh"

module ifs_engine_model
  import ifs_pkg::*;
(
  // Clock and bench controls
  input wire logic                   sys_clk,
  input wire logic                   drain_en,
  input wire logic                   push_go,
  input wire logic                   rd_addr_go,
  input wire logic                   wr_addr_go,
  input wire logic                   rd_active_go,
  // Tx drain side
  input wire logic                   tx_valid,
  input wire logic [`IFS_DATA_W-1:0] tx_data,
  output logic                       tx_ready,
  // Rx fill side
  output logic                       rx_push,
  output logic [`IFS_DATA_W-1:0]     rx_push_data,
  // Slave events and observations
  output ifs_pkg::ifs_slave_evt_t    slave_evt,
  output int                         n_drained,
  output logic [`IFS_DATA_W-1:0]     first_byte
);
  logic [`IFS_DATA_W-1:0] seq = 8'h80;

  // Quiet outputs at time zero
  initial begin
    tx_ready = 1'b0;
    rx_push = 1'b0;
    rx_push_data = 8'h00;
    slave_evt = '0;
    n_drained = 0;
    first_byte = 8'h00;
  end

  // One step of the far side per clock
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) begin
      if (n_drained == 0) first_byte <= tx_data;
      n_drained <= n_drained + 1;
    end
    tx_ready <= drain_en;
    rx_push <= push_go;
    rx_push_data <= push_go ? seq : ~rx_push_data; // Idle data keeps moving
    if (push_go) seq <= seq + 8'h01;
    slave_evt <= '{read_addressed: rd_addr_go, write_addressed: wr_addr_go, read_active: rd_active_go};
  end
endmodule : ifs_engine_model
`default_nettype wire

// *** testbench/ifs_flags_properties.sv ***
/*
  Port timing checks for ifs_flags, attached by bind.
  Assumes the bench keeps bready and rready high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ifs_defs.svh"

module ifs_flags_properties
  import ifs_pkg::*;
(
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    reset,
  // Register bus
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  // Engine side and interrupt
  input wire logic                    tx_valid,
  input wire logic [`IFS_DATA_W-1:0]  tx_data,
  input wire logic                    tx_ready,
  input wire ifs_pkg::ifs_slave_evt_t slave_evt,
  input wire logic                    irq
);
  logic wr_seen;

  // Any register write since reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) wr_seen <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready) wr_seen <= 1'b1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Write taken on both channels, then a hold cycle, then the answer
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp_due;
    !s_axi_bvalid && !s_axi_awready ##1 s_axi_bvalid;
  endsequence

  a_write_answer: assert property (s_wr_taken |=> s_resp_due)
    else $error("write answer not two cycles after acceptance");
  a_busy_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `IFS_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_read_flush: assert property (slave_evt.read_addressed |=> !tx_valid)
    else $error("tx data kept after slave read address");
  a_irq_masked: assert property (!wr_seen |-> !irq)
    else $error("interrupt with mask at reset value");
  a_tx_stands: assert property (tx_valid && !tx_ready && !slave_evt.read_addressed && s_axi_awready
                                |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed while stalled");
endmodule : ifs_flags_properties

bind ifs_flags ifs_flags_properties u_ifs_flags_properties (
  .sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .tx_valid, .tx_data, .tx_ready, .slave_evt, .irq
);
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for ifs_flags with the serial engine model.
  Assumes package, header, design and model compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ifs_defs.svh"

module tb_top;
  import ifs_pkg::*;
  logic                   sys_clk, reset, irq;
  logic [7:0]             s_axi_awaddr, s_axi_araddr;
  logic [31:0]            s_axi_wdata, s_axi_rdata;
  logic [3:0]             s_axi_wstrb;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                   s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic                   tx_valid, tx_ready, rx_push;
  logic [`IFS_DATA_W-1:0] tx_data, rx_push_data, first_byte;
  ifs_slave_evt_t         slave_evt;
  logic                   drain_en, push_go, rd_addr_go, wr_addr_go, rd_active_go;
  int                     n_drained, n_mismatch, check_count;
  localparam logic [7:0]  RAW = `IFS_OFF_RAW_STATUS;

  ifs_flags u_ifs_flags (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_valid,
    .tx_data, .tx_ready, .rx_push, .rx_push_data, .slave_evt, .irq);
  ifs_engine_model u_ifs_engine_model (.sys_clk, .drain_en, .push_go, .rd_addr_go, .wr_addr_go,
    .rd_active_go, .tx_valid, .tx_data, .tx_ready, .rx_push, .rx_push_data, .slave_evt, .n_drained,
    .first_byte);

  // Verdict and run end
  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic timed_out();
    n_mismatch++;
    $display("unexpected at %0t: wait limit used up", $time);
    print_verdict();
  endtask : timed_out

  // Readies are looked at on the falling edge, valid is dropped after the rising one
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_done;
    logic [1:0] r;
    b_done = 1'b0;
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int i = 0; i < 20 && !b_done; i++) begin
      @(negedge sys_clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_done = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    if (!b_done) timed_out();
    check_sig(r === `IFS_RESP_OKAY, 1'b1);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_done;
    r_done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int i = 0; i < 20 && !r_done; i++) begin
      @(negedge sys_clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    if (!r_done) timed_out();
  endtask : axi_read

  task automatic check_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check_count++;
    if ((d & m) !== e || r !== `IFS_RESP_OKAY) begin
      n_mismatch++;
      $display("unexpected at %0t: reg %h reads %h", $time, a, d);
    end
  endtask : check_reg

  task automatic check_sig(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: level %b not %b", $time, g, e);
    end
  endtask : check_sig

  // Engine pushes n rx bytes, then the flags settle
  task automatic push_rx(input int n);
    push_go <= 1'b1;
    repeat (n) @(posedge sys_clk);
    push_go <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : push_rx

  task automatic test_reset();
    logic [31:0] d;
    logic [1:0]  r;
    check_reg(RAW, 32'hffff_ffff, 32'h0000_0033);
    check_reg(`IFS_OFF_MASK, 32'hffff_ffff, 32'h0);
    axi_read(8'h40, d, r);
    check_sig(r === `IFS_RESP_SLVERR && d === 32'h0, 1'b1);
  endtask : test_reset

  task automatic test_tx();
    axi_write(`IFS_OFF_TX_THRESH, 32'h2);
    for (int k = 1; k <= `IFS_FIFO_DEPTH; k++) begin
      axi_write(`IFS_OFF_TX_DATA, 32'(k));
      if (k == 2) check_reg(RAW, 32'h2, 32'h2);
      if (k == 3) check_reg(RAW, 32'h2, 32'h0);
      if (k == 15) check_reg(RAW, 32'h4, 32'h0);
    end
    check_reg(RAW, 32'he, 32'h4);
    axi_write(`IFS_OFF_TX_DATA, 32'h99);
    check_reg(RAW, 32'he, 32'hc);
    drain_en <= 1'b1;
    for (int i = 0; tx_valid !== 1'b0; i++) begin
      if (i == 100) timed_out();
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    drain_en <= 1'b0;
    check_sig(n_drained == `IFS_FIFO_DEPTH && first_byte === 8'h01, 1'b1);
    check_reg(RAW, 32'hf, 32'hb);
    axi_write(`IFS_OFF_CLEAR, 32'h8);
    check_reg(RAW, 32'h8, 32'h0);
    axi_write(`IFS_OFF_TX_DATA, 32'h11);
    axi_write(`IFS_OFF_CONTROL, 32'h1);
    check_reg(RAW, 32'h1, 32'h1);
  endtask : test_tx

  task automatic test_rx();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(`IFS_OFF_RX_THRESH, 32'h2);
    push_rx(1);
    check_reg(RAW, 32'h70, 32'h0);
    push_rx(1);
    check_reg(RAW, 32'h70, 32'h20);
    push_rx(`IFS_FIFO_DEPTH - 2);
    check_reg(RAW, 32'h70, 32'h60);
    axi_read(`IFS_OFF_RX_DATA, d, r);
    check_sig(d[7:0] === 8'h80, 1'b1);
    check_reg(RAW, 32'h70, 32'h20);
  endtask : test_rx

  task automatic test_slave();
    axi_write(`IFS_OFF_TX_DATA, 32'h55);
    rd_addr_go <= 1'b1;
    @(posedge sys_clk);
    rd_addr_go <= 1'b0;
    rd_active_go <= 1'b1;
    // Model then design each take one edge
    repeat (2) @(posedge sys_clk);
    check_reg(RAW, 32'h3_0001, 32'h3_0001);
    axi_write(`IFS_OFF_TX_DATA, 32'h66);
    check_reg(RAW, 32'h3_0000, 32'h0);
    rd_active_go <= 1'b0;
    wr_addr_go <= 1'b1;
    @(posedge sys_clk);
    wr_addr_go <= 1'b0;
    @(posedge sys_clk);
    check_reg(RAW, 32'h4_0000, 32'h4_0000);
    axi_write(`IFS_OFF_MASK, 32'h4_0000);
    @(negedge sys_clk);
    check_sig(irq, 1'b1);
    @(posedge sys_clk);
    axi_write(`IFS_OFF_CLEAR, 32'h4_0000);
    @(negedge sys_clk);
    check_sig(irq, 1'b0);
    @(posedge sys_clk);
  endtask : test_slave

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    {drain_en, push_go, rd_addr_go, wr_addr_go, rd_active_go} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    test_reset();
    test_tx();
    test_rx();
    test_slave();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// *** verilog/ifs_defs.svh ***
/*
  Offsets, field positions, reset values and sizes for the FIFO status flag block.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Notes on behaviour
// - Tx threshold flag high while tx occupancy is at or below tx threshold.
// - Tx full flag follows tx FIFO full, clears itself, resets to zero.
// - Writing a full tx FIFO sets the overrun flag; that word is lost.
// - Overrun flag holds until software writes one to the clear register.
// - Rx empty flag high while the rx FIFO holds no entries.
// - Rx threshold flag high while rx occupancy is at or above rx threshold.
// - Rx full flag sets on rx FIFO full, clears when rx data is read.
// - Slave read address sets read request flag and flushes the tx FIFO.
// - Software loads tx data; a tx FIFO write clears the read request flag.
// - Slave read with empty tx FIFO sets bit 17; tx write clears it.
// - Slave write address sets the write request flag.
// - Each flag reaches the interrupt only when its mask bit is one.
`ifndef IFS_DEFS_SVH
`define IFS_DEFS_SVH

// Register byte offsets
`define IFS_OFF_CONTROL    8'h00
`define IFS_OFF_TX_THRESH  8'h04
`define IFS_OFF_RX_THRESH  8'h08
`define IFS_OFF_TX_DATA    8'h10
`define IFS_OFF_RX_DATA    8'h14
`define IFS_OFF_MASK       8'h2c
`define IFS_OFF_RAW_STATUS 8'h30
`define IFS_OFF_MASKED     8'h34
`define IFS_OFF_CLEAR      8'h38

// Control fields
`define IFS_CTL_FLUSH_TX   0

// Status bit positions
`define IFS_BIT_TX_EMPTY   0
`define IFS_BIT_TX_BELOW   1
`define IFS_BIT_TX_FULL    2
`define IFS_BIT_TX_OVR     3
`define IFS_BIT_RX_EMPTY   4
`define IFS_BIT_RX_ABOVE   5
`define IFS_BIT_RX_FULL    6
`define IFS_BIT_RD_REQ     16
`define IFS_BIT_RD_EMPTY   17
`define IFS_BIT_WR_REQ     18

// Reset values
`define IFS_RST_MASK       32'h0000_0000
`define IFS_RST_THRESH     5'h00

// FIFO geometry and bus answers
`define IFS_FIFO_DEPTH     16
`define IFS_FIFO_AW        4
`define IFS_DATA_W         8
`define IFS_RESP_OKAY      2'h0
`define IFS_RESP_SLVERR    2'h2

`endif

// *** verilog/ifs_fifo.sv ***
/*
  Small synchronous FIFO with occupancy count and flush.
  Ignores a push given while full; the tx caller also filters that.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ifs_defs.svh"

module ifs_fifo (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  // Fill side
  input  wire logic                      push,
  input  wire logic [`IFS_DATA_W-1:0]    push_data,
  // Drain side
  input  wire logic                      pop,
  output logic      [`IFS_DATA_W-1:0]    head,
  // Control and state
  input  wire logic                      flush,
  output logic      [`IFS_FIFO_AW:0]     count
);
  logic [`IFS_DATA_W-1:0]  mem [`IFS_FIFO_DEPTH];
  logic [`IFS_FIFO_AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [`IFS_FIFO_AW:0]   next_count;
  logic                    do_push, do_pop;

  // Pointer and count update
  always_comb begin
    do_push    = push && (count != 5'(`IFS_FIFO_DEPTH)) && !flush;
    do_pop     = pop && (count != 5'h00) && !flush;
    next_wptr  = do_push ? wptr + 4'h1 : wptr;
    next_rptr  = do_pop ? rptr + 4'h1 : rptr;
    next_count = count + (do_push ? 5'h01 : 5'h00) - (do_pop ? 5'h01 : 5'h00);
    if (flush) begin
      next_wptr  = 4'h0;
      next_rptr  = 4'h0;
      next_count = 5'h00;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wptr  <= 4'h0;
      rptr  <= 4'h0;
      count <= 5'h00;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wptr] <= push_data;
    end
  end

  assign head = mem[rptr];
endmodule : ifs_fifo
`default_nettype wire

// *** verilog/ifs_flags.sv ***
/*
  FIFO and slave request status flags of a two-wire serial controller,
  with tx and rx FIFOs, threshold, mask and clear registers on AXI4-Lite.
  Assumes the serial engine runs on sys_clk and drives its events as pulses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ifs_defs.svh"

module ifs_flags
  import ifs_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // AXI4-Lite write address
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Serial engine, tx drain
  output logic                        tx_valid,
  output logic [`IFS_DATA_W-1:0]      tx_data,
  input  wire logic                   tx_ready,
  // Serial engine, rx fill
  input  wire logic                   rx_push,
  input  wire logic [`IFS_DATA_W-1:0] rx_push_data,
  // Serial engine, slave events
  input  wire ifs_pkg::ifs_slave_evt_t slave_evt,
  // Interrupt
  output logic                        irq
);
  import ifs_pkg::*;

  // Bus state
  ifs_wr_state_t       wr_state, next_wr_state;
  logic                aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0]          aw_addr, next_aw_addr;
  logic [31:0]         w_data, next_w_data;
  logic [3:0]          w_strb, next_w_strb;
  logic [1:0]          bresp, next_bresp;
  logic                rvalid, next_rvalid;
  logic [31:0]         rdata, next_rdata;
  logic [1:0]          rresp, next_rresp;

  // Software registers
  logic [`IFS_FIFO_AW:0] tx_threshold_register, next_tx_thr;
  logic [`IFS_FIFO_AW:0] rx_threshold_register, next_rx_thr;
  logic [31:0]           mask, next_mask;

  // Datapath strobes
  logic                do_wr, do_rd, wr_hit, wr_b0;
  logic                tx_wr, tx_push, tx_pop, rx_pop, flush_tx;
  logic [31:0]         clear_bits, wmask, raw_interrupt_status;
  logic [`IFS_FIFO_AW:0] tx_count, rx_count;
  logic [`IFS_DATA_W-1:0] rx_head;
  logic                tx_empty, tx_full, rx_empty, rx_full_now;
  logic [4:0]          st_set, st_clr, st_flag;
  logic                tx_overrun_flag, rx_full_flag, slave_read_request_flag;
  logic                slave_read_empty_flag, slave_write_request_flag;

  // Write channel: take address and data in either order, answer after both
  always_comb begin
    next_wr_state = wr_state;
    next_aw_hold  = aw_hold;
    next_w_hold   = w_hold;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bresp    = bresp;
    do_wr         = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    unique case (wr_state)
      IFS_WR_IDLE: begin
        if (aw_hold && w_hold) begin
          do_wr         = 1'b1;
          next_aw_hold  = 1'b0;
          next_w_hold   = 1'b0;
          next_bresp    = wr_hit ? `IFS_RESP_OKAY : `IFS_RESP_SLVERR;
          next_wr_state = IFS_WR_RESP;
        end
      end
      IFS_WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = IFS_WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_state <= IFS_WR_IDLE;
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      aw_addr  <= 8'h00;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      bresp    <= `IFS_RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      aw_hold  <= next_aw_hold;
      w_hold   <= next_w_hold;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bresp    <= next_bresp;
    end
  end

  assign s_axi_awready = !aw_hold && (wr_state == IFS_WR_IDLE);
  assign s_axi_wready  = !w_hold && (wr_state == IFS_WR_IDLE);
  assign s_axi_bvalid  = (wr_state == IFS_WR_RESP);
  assign s_axi_bresp   = bresp;

  // Write decode
  always_comb begin
    wr_hit = (aw_addr == `IFS_OFF_CONTROL) || (aw_addr == `IFS_OFF_TX_THRESH) ||
             (aw_addr == `IFS_OFF_RX_THRESH) || (aw_addr == `IFS_OFF_TX_DATA) ||
             (aw_addr == `IFS_OFF_MASK) || (aw_addr == `IFS_OFF_CLEAR);
    wr_b0  = do_wr && w_strb[0];
    wmask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    tx_wr  = wr_b0 && (aw_addr == `IFS_OFF_TX_DATA);
    flush_tx = (wr_b0 && (aw_addr == `IFS_OFF_CONTROL) && w_data[`IFS_CTL_FLUSH_TX]) ||
               slave_evt.read_addressed;
    clear_bits = (do_wr && (aw_addr == `IFS_OFF_CLEAR)) ? (w_data & wmask) : 32'h0000_0000;
  end

  // Register file update
  always_comb begin
    next_tx_thr = tx_threshold_register;
    next_rx_thr = rx_threshold_register;
    next_mask   = mask;
    if (wr_b0 && (aw_addr == `IFS_OFF_TX_THRESH)) begin
      next_tx_thr = w_data[`IFS_FIFO_AW:0];
    end
    if (wr_b0 && (aw_addr == `IFS_OFF_RX_THRESH)) begin
      next_rx_thr = w_data[`IFS_FIFO_AW:0];
    end
    if (do_wr && (aw_addr == `IFS_OFF_MASK)) begin
      next_mask = (mask & ~wmask) | (w_data & wmask);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_threshold_register <= `IFS_RST_THRESH;
      rx_threshold_register <= `IFS_RST_THRESH;
      mask                  <= `IFS_RST_MASK;
    end else begin
      tx_threshold_register <= next_tx_thr;
      rx_threshold_register <= next_rx_thr;
      mask                  <= next_mask;
    end
  end

  // Read channel: one read at a time, answer one cycle after address
  always_comb begin
    do_rd       = s_axi_arvalid && s_axi_arready;
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    rx_pop      = 1'b0;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (do_rd) begin
      next_rvalid = 1'b1;
      next_rresp  = `IFS_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `IFS_OFF_CONTROL:    next_rdata = 32'h0000_0000;
        `IFS_OFF_TX_THRESH:  next_rdata = {27'h0, tx_threshold_register};
        `IFS_OFF_RX_THRESH:  next_rdata = {27'h0, rx_threshold_register};
        `IFS_OFF_TX_DATA:    next_rdata = 32'h0000_0000;
        `IFS_OFF_RX_DATA: begin
          next_rdata = {24'h0, rx_head};
          rx_pop     = !rx_empty;
        end
        `IFS_OFF_MASK:       next_rdata = mask;
        `IFS_OFF_RAW_STATUS: next_rdata = raw_interrupt_status;
        `IFS_OFF_MASKED:     next_rdata = raw_interrupt_status & mask;
        `IFS_OFF_CLEAR:      next_rdata = 32'h0000_0000;
        default:             next_rresp = `IFS_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `IFS_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // Transmit FIFO, filled by software, drained by the serial engine
  ifs_fifo u_tx_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (tx_push),
    .push_data (w_data[`IFS_DATA_W-1:0]),
    .pop       (tx_pop),
    .head      (tx_data),
    .flush     (flush_tx),
    .count     (tx_count)
  );

  // Receive FIFO, filled by the serial engine, drained by software
  ifs_fifo u_rx_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .push      (rx_push),
    .push_data (rx_push_data),
    .pop       (rx_pop),
    .head      (rx_head),
    .flush     (1'b0),
    .count     (rx_count)
  );

  // FIFO levels
  always_comb begin
    tx_empty    = (tx_count == 5'h00);
    tx_full     = (tx_count == 5'(`IFS_FIFO_DEPTH));
    rx_empty    = (rx_count == 5'h00);
    rx_full_now = (rx_count == 5'(`IFS_FIFO_DEPTH));
    tx_push     = tx_wr && !tx_full;
    tx_valid    = !tx_empty;
    tx_pop      = tx_valid && tx_ready;
  end

  // Sticky flag events; set beats clear in the same cycle
  always_comb begin
    st_set    = '0;
    st_clr    = '0;
    st_set[0] = tx_wr && tx_full;
    st_clr[0] = clear_bits[`IFS_BIT_TX_OVR];
    st_set[1] = rx_full_now && !rx_pop;
    st_clr[1] = rx_pop;
    st_set[2] = slave_evt.read_addressed;
    st_clr[2] = tx_wr;
    st_set[3] = slave_evt.read_active && tx_empty && !tx_wr;
    st_clr[3] = tx_wr;
    st_set[4] = slave_evt.write_addressed;
    st_clr[4] = clear_bits[`IFS_BIT_WR_REQ];
  end

  ifs_sticky #(
    .WIDTH (5)
  ) u_sticky (
    .sys_clk (sys_clk),
    .reset   (reset),
    .set     (st_set),
    .clr     (st_clr),
    .flag    (st_flag)
  );

  assign tx_overrun_flag          = st_flag[0];
  assign rx_full_flag             = st_flag[1];
  assign slave_read_request_flag  = st_flag[2];
  assign slave_read_empty_flag    = st_flag[3];
  assign slave_write_request_flag = st_flag[4];

  // Raw status image
  always_comb begin
    raw_interrupt_status = 32'h0000_0000;
    raw_interrupt_status[`IFS_BIT_TX_EMPTY] = tx_empty;
    raw_interrupt_status[`IFS_BIT_TX_BELOW] = (tx_count <= tx_threshold_register);
    raw_interrupt_status[`IFS_BIT_TX_FULL]  = tx_full;
    raw_interrupt_status[`IFS_BIT_TX_OVR]   = tx_overrun_flag;
    raw_interrupt_status[`IFS_BIT_RX_EMPTY] = rx_empty;
    raw_interrupt_status[`IFS_BIT_RX_ABOVE] = (rx_count >= rx_threshold_register);
    raw_interrupt_status[`IFS_BIT_RX_FULL]  = rx_full_flag;
    raw_interrupt_status[`IFS_BIT_RD_REQ]   = slave_read_request_flag;
    raw_interrupt_status[`IFS_BIT_RD_EMPTY] = slave_read_empty_flag;
    raw_interrupt_status[`IFS_BIT_WR_REQ]   = slave_write_request_flag;
  end

  // Level interrupt from enabled flags
  assign irq = |(raw_interrupt_status & mask);
endmodule : ifs_flags
`default_nettype wire

// *** verilog/ifs_pkg.sv ***
/*
  Types for the FIFO status flag block.
  Assumes ifs_defs.svh is on the include path.
*/
`include "ifs_defs.svh"

package ifs_pkg;

  // Slave side events from the serial engine
  typedef struct packed {
    logic read_addressed;
    logic write_addressed;
    logic read_active;
  } ifs_slave_evt_t;

  // Write channel state
  typedef enum logic [1:0] {
    IFS_WR_IDLE = 2'b01,
    IFS_WR_RESP = 2'b10
  } ifs_wr_state_t;

endpackage : ifs_pkg

// *** verilog/ifs_sticky.sv ***
/*
  Vector of sticky flags; a set in the same cycle as a clear wins.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module ifs_sticky #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Set and clear per bit
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flag
);
  logic [WIDTH-1:0] next_flag;

  // Set has priority over clear
  always_comb begin
    next_flag = (flag & ~clr) | set;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flag <= '0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule : ifs_sticky
`default_nettype wire
